//--- flash_pin_pkg.sv
/*
  Constants and types for the serial flash pin interface.
  Assumes one die, 25-bit byte address, status bits held outside.
*/
`default_nettype none
package flash_pin_pkg;
  // ==========================================================
  // Address map
  localparam int ADDR_W     = 25;
  localparam int SECTOR_LSB = 12;
  localparam int HALF_LSB   = 15;
  localparam int BLOCK_LSB  = 16;
  localparam int BIG_LSB    = 19;
  localparam logic [24:0] LAST_SECTOR_BASE = 25'h1ff_f000;

  // ==========================================================
  // Shifting
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [7:0] TX_IDLE_BYTE = 8'hff;
  localparam logic [1:0] BUF_DEPTH    = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    LANE_ONE  = 3'b001,
    LANE_TWO  = 3'b010,
    LANE_FOUR = 3'b100
  } lane_mode_t;

  typedef enum logic [1:0] {
    LINK_RUN   = 2'b01,
    LINK_PAUSE = 2'b10
  } link_state_t;

  typedef struct packed {
    logic status_protect_high;
    logic status_protect_low;
    logic quad_enable;
    logic pause_reset_select;
  } status_cfg_t;

  typedef struct packed {
    logic [12:0] sector;
    logic [9:0]  half_block;
    logic [8:0]  block;
    logic [5:0]  big_block;
    logic        last_sector;
  } addr_map_t;

  typedef struct packed {
    logic        cs1;
    logic        cs2;
    logic        cs_prev;
    logic        ck1;
    logic        ck2;
    logic        ck_prev;
    logic [3:0]  io1;
    logic [3:0]  io2;
    logic        rp1;
    logic        rp2;
    logic        seen_fall;
    link_state_t pstate;
    logic        paused;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic [7:0]  tx_sh;
    logic [3:0]  tx_cnt;
    logic        tx_take;
    logic [7:0]  buf0;
    logic [7:0]  buf1;
    logic [1:0]  buf_cnt;
    logic        rx_valid;
    logic        overrun;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic        power_active;
    logic        standby;
    logic        die_reset;
    logic        status_write_ok;
    logic        array_write_ok;
    addr_map_t   map;
  } pin_state_t;
endpackage
`default_nettype wire

//--- host_model.sv
/*
  Model of the host controller that drives the flash pins.
  Assumes a 100 ns block clock; one serial half period is 4 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  output var  logic       cs_n,
  output var  logic       sclk,
  output var  logic [3:0] drv,
  output var  logic [3:0] en,
  input  wire logic [3:0] pin
);
  // ==========================================================
  // Idle: deselected, clock low, all lines released
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv = 4'h0;
    en = 4'h0;
  end

  // Pins change just after a block clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Frame edges; a falling select opens every frame
  task automatic sel(input logic on);
    tick(4);
    cs_n = ~on;
    tick(4);
  endtask

  // Direct control of the clock and the spare lines
  task automatic pins(input logic c, input logic [3:0] e,
                      input logic [3:0] d);
    sclk = c;
    en = e;
    drv = d;
    tick(1);
  endtask

  // One byte, w bits per clock, MSB first; clock ends high so the
  // next frame runs in mode 3
  task automatic xfer(input logic [7:0] tx, input int w,
                      input logic rd, output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      sclk = 1'b0;
      en = rd ? 4'h0 : 4'((5'h01 << w) - 5'h01);
      drv = (w == 1) ? {3'h0, sh[7]} :
            (w == 2) ? {2'h0, sh[7:6]} : sh[7:4];
      sh = sh << w;
      tick(4);
      sclk = 1'b1;
      tick(4);
      rx = (w == 1) ? {rx[6:0], pin[1]} :
           (w == 2) ? {rx[5:0], pin[1:0]} : {rx[3:0], pin};
    end
    // Let an edge pass so a following call never re-drives at once
    tick(1);
    en = 4'h0;
  endtask
endmodule
`default_nettype wire

//--- serial_flash_pin_interface.sv
/*
  Pin-side logic of one serial flash die, oversampling the serial
  clock with MCLK. Assumes SCLK well below MCLK/4, and that the
  instruction decoder supplies lane mode, output phase and busy.
*/
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Chip select high deselects, serial clock and data ignored, all outputs released.
// - Deselected and not busy means standby power.
// - Chip select low selects and means active power.
// - Input bits are taken on the serial clock rising edge.
// - Output bits change only after a falling edge, one lane group (1, 2 or 4 bits) per edge.
// - Dual and quad use lines 0 and 1 both ways.
// - Protect pin low with protect bits 0/1 blocks status writes.
// - Same condition blocks program and erase in protected regions.
// - Quad enable turns the protect pin into data line 2.
// - Quad enable makes the shared pin only data line 3.
// - Without quad, a status bit picks pause or reset use.
// - Pause low suspends the link, internal operations carry on.
// - Pause starts on pause low with select low, clock low.
// - Pause ends on pause high, waiting for a low clock.
// - The dedicated reset pin returns the die to power-up state.
// - Sectors are 4 KB, numbered by address bits 12 and up.
// - Eight sectors form an aligned 32 KB half block.
// - 64 KB blocks and 4 Mbit big blocks, size aligned.
// - 8192 sectors, last one starting at 1FFF000h.
// - Select bit 1 makes shared pin reset, 0 makes it pause.
// - Clock may idle low or high between frames.
module serial_flash_pin_interface
  import flash_pin_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        CS_N,
  input  wire logic        SCLK,
  input  wire logic [3:0]  IO_IN,
  output var  logic [3:0]  IO_OUT,
  output var  logic [3:0]  IO_OE,
  input  wire logic        RESET_PIN_N,
  input  wire status_cfg_t STATUS_CFG,
  input  wire lane_mode_t  LANE_MODE,
  input  wire logic        TX_PHASE,
  input  wire logic [7:0]  TX_DATA,
  input  wire logic        TX_VALID,
  output var  logic        TX_TAKE,
  output var  logic [7:0]  RX_DATA,
  output var  logic        RX_VALID,
  input  wire logic        RX_READY,
  output var  logic        RX_OVERRUN,
  input  wire logic        OP_BUSY,
  input  wire logic        REGION_PROTECTED,
  input  wire logic [24:0] ADDR,
  output var  addr_map_t   ADDR_MAP,
  output var  logic        POWER_ACTIVE,
  output var  logic        STANDBY,
  output var  logic        DIE_RESET,
  output var  logic        PAUSED,
  output var  logic        ARMED,
  output var  logic        STATUS_WRITE_OK,
  output var  logic        ARRAY_WRITE_OK
);

  // ==========================================================
  // State
  pin_state_t s;
  pin_state_t next_s;

  logic       sel;
  logic       rise;
  logic       fall;
  logic       qe;
  logic       pause_fn;
  logic       rst_fn;
  logic       dev_rst;
  logic       active;
  logic       hw_lock;
  lane_mode_t lm;

  // Decoded conditions; pin levels from synchronised copies, config used directly
  assign sel      = !s.cs2;
  assign rise     = s.ck2 && !s.ck_prev;
  assign fall     = !s.ck2 && s.ck_prev;
  assign qe       = STATUS_CFG.quad_enable;
  assign pause_fn = !qe && !STATUS_CFG.pause_reset_select;
  assign rst_fn   = !qe && STATUS_CFG.pause_reset_select;
  assign dev_rst  = !s.rp2 || (rst_fn && !s.io2[3]);
  assign active   = sel && s.seen_fall && s.pstate == LINK_RUN;
  // Protect pin is line 2 under quad, so it cannot lock then
  assign hw_lock  = !qe && !s.io2[2]
                    && !STATUS_CFG.status_protect_high
                    && STATUS_CFG.status_protect_low;
  // Quad lanes only exist with quad enable set
  assign lm = (LANE_MODE == LANE_FOUR && !qe) ? LANE_ONE : LANE_MODE;

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] w;
    logic [3:0] cnt;
    logic [1:0] bcnt;
    logic [7:0] rsh;
    logic [3:0] step;
    logic       push;
    w    = s.tx_sh;
    cnt  = s.tx_cnt;
    bcnt = s.buf_cnt;
    rsh  = s.rx_sh;
    step = 4'h1;
    push = 1'b0;
    next_s = s;

    // Two-flop synchronisers; first stage feeds only the second
    next_s.cs1     = CS_N;
    next_s.cs2     = s.cs1;
    next_s.cs_prev = s.cs2;
    next_s.ck1     = SCLK;
    next_s.ck2     = s.ck1;
    next_s.ck_prev = s.ck2;
    next_s.io1     = IO_IN;
    next_s.io2     = s.io1;
    next_s.rp1     = RESET_PIN_N;
    next_s.rp2     = s.rp1;
    next_s.tx_take = 1'b0;

    // First falling edge of select arms the die
    if (s.cs_prev && !s.cs2) begin
      next_s.seen_fall = 1'b1;
      next_s.overrun   = 1'b0;
    end

    // Pause: both edges wait for a low clock phase
    unique case (s.pstate)
      LINK_RUN:
        if (pause_fn && sel && !s.io2[3] && !s.ck2) begin
          next_s.pstate = LINK_PAUSE;
        end
      LINK_PAUSE:
        if (!pause_fn || !sel || (s.io2[3] && !s.ck2)) begin
          next_s.pstate = LINK_RUN;
        end
      default: next_s.pstate = LINK_RUN;
    endcase
    next_s.paused = next_s.pstate == LINK_PAUSE;

    // Receive: sample lanes on the rising edge
    if (active && rise && !TX_PHASE) begin
      unique case (lm)
        LANE_ONE: rsh = {s.rx_sh[6:0], s.io2[0]};
        LANE_TWO: begin
          rsh  = {s.rx_sh[5:0], s.io2[1:0]};
          step = 4'h2;
        end
        LANE_FOUR: begin
          rsh  = {s.rx_sh[3:0], s.io2};
          step = 4'h4;
        end
        default: rsh = s.rx_sh;
      endcase
      next_s.rx_sh  = rsh;
      next_s.rx_cnt = s.rx_cnt + step;
      if (s.rx_cnt + step == BYTE_BITS) begin
        push          = 1'b1;
        next_s.rx_cnt = 4'h0;
      end
    end

    // Two-entry buffer; a full buffer flags overrun, set beats clear
    if (RX_READY && s.rx_valid) begin
      next_s.buf0 = s.buf1;
      bcnt        = bcnt - 2'h1;
    end
    if (push) begin
      if (bcnt == BUF_DEPTH) begin
        next_s.overrun = 1'b1;
      end else begin
        if (bcnt == 2'h0) begin
          next_s.buf0 = rsh;
        end else begin
          next_s.buf1 = rsh;
        end
        bcnt = bcnt + 2'h1;
      end
    end
    next_s.buf_cnt  = bcnt;
    next_s.rx_valid = bcnt != 2'h0;

    // Transmit: new bits only after a falling edge
    if (active && fall && TX_PHASE) begin
      if (s.tx_cnt == 4'h0) begin
        w              = TX_VALID ? TX_DATA : TX_IDLE_BYTE;
        next_s.tx_take = TX_VALID;
        cnt            = BYTE_BITS;
      end
      unique case (lm)
        LANE_ONE: begin
          next_s.io_out = {2'b00, w[7], 1'b0};
          next_s.io_oe  = 4'b0010;
          next_s.tx_sh  = {w[6:0], 1'b0};
          next_s.tx_cnt = cnt - 4'h1;
        end
        LANE_TWO: begin
          next_s.io_out = {2'b00, w[7:6]};
          next_s.io_oe  = 4'b0011;
          next_s.tx_sh  = {w[5:0], 2'b00};
          next_s.tx_cnt = cnt - 4'h2;
        end
        LANE_FOUR: begin
          next_s.io_out = w[7:4];
          next_s.io_oe  = 4'b1111;
          next_s.tx_sh  = {w[3:0], 4'h0};
          next_s.tx_cnt = cnt - 4'h4;
        end
        default: next_s.io_oe = 4'h0;
      endcase
    end
    // Release lines while paused, deselected or receiving
    if (!active || !TX_PHASE) begin
      next_s.io_oe = 4'h0;
    end
    // End of frame drops partial bytes
    if (!sel) begin
      next_s.rx_cnt = 4'h0;
      next_s.tx_cnt = 4'h0;
    end

    // Power state follows select and internal work
    next_s.power_active = sel || OP_BUSY;
    next_s.standby      = !sel && !OP_BUSY;

    // Hardware write protection
    next_s.status_write_ok = !hw_lock;
    next_s.array_write_ok  = !(hw_lock && REGION_PROTECTED);

    // Uniform address map
    next_s.map.sector      = ADDR[ADDR_W-1:SECTOR_LSB];
    next_s.map.half_block  = ADDR[ADDR_W-1:HALF_LSB];
    next_s.map.block       = ADDR[ADDR_W-1:BLOCK_LSB];
    next_s.map.big_block   = ADDR[ADDR_W-1:BIG_LSB];
    next_s.map.last_sector = ADDR >= LAST_SECTOR_BASE;

    // Pin reset returns the protocol side to its power-up state
    next_s.die_reset = dev_rst;
    if (dev_rst) begin
      next_s.seen_fall = 1'b0;
      next_s.pstate    = LINK_RUN;
      next_s.paused    = 1'b0;
      next_s.rx_cnt    = 4'h0;
      next_s.tx_cnt    = 4'h0;
      next_s.buf_cnt   = 2'h0;
      next_s.rx_valid  = 1'b0;
      next_s.overrun   = 1'b0;
      next_s.io_oe     = 4'h0;
      next_s.tx_take   = 1'b0;
    end
  end

  // Register; synchronous reset to idle, deselected levels
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s         <= '0;
      s.cs1     <= 1'b1;
      s.cs2     <= 1'b1;
      s.cs_prev <= 1'b1;
      s.rp1     <= 1'b1;
      s.rp2     <= 1'b1;
      // Lines 2 and 3 idle pulled high, so no false lock or reset
      s.io1     <= 4'hc;
      s.io2     <= 4'hc;
      s.pstate  <= LINK_RUN;
      s.standby <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs, all flop fields
  assign IO_OUT          = s.io_out;
  assign IO_OE           = s.io_oe;
  assign TX_TAKE         = s.tx_take;
  assign RX_DATA         = s.buf0;
  assign RX_VALID        = s.rx_valid;
  assign RX_OVERRUN      = s.overrun;
  assign ADDR_MAP        = s.map;
  assign POWER_ACTIVE    = s.power_active;
  assign STANDBY         = s.standby;
  assign DIE_RESET       = s.die_reset;
  assign PAUSED          = s.paused;
  assign ARMED           = s.seen_fall;
  assign STATUS_WRITE_OK = s.status_write_ok;
  assign ARRAY_WRITE_OK  = s.array_write_ok;

  // ==========================================================
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence rx_one_seq;
    active && rise && !TX_PHASE && lm == LANE_ONE;
  endsequence

  a_deselect_quiet: assert property (
    !sel |=> IO_OE == 4'h0) else $error("Driving while deselected");
  a_standby_power: assert property (
    (!sel && !OP_BUSY) |=> STANDBY && !POWER_ACTIVE)
    else $error("Not in standby");
  a_select_active: assert property (
    $fell(s.cs2) |=> POWER_ACTIVE) else $error("Select not active");
  a_unarmed_idle: assert property (
    !s.seen_fall |=> s.rx_cnt == 4'h0) else $error("Shift before arm");
  a_rise_sample: assert property (
    rx_one_seq |=> s.rx_sh[0] == $past(s.io2[0]))
    else $error("Bit not sampled");
  a_fall_drive: assert property (
    $changed(IO_OUT) |-> $past(fall)) else $error("Output off fall");
  a_dual_lanes: assert property (
    $rose(IO_OE[0]) |-> $past(lm != LANE_ONE))
    else $error("Line 0 driven single");
  a_status_lock: assert property (
    hw_lock |=> !STATUS_WRITE_OK) else $error("Status write open");
  a_quad_no_wp: assert property (
    qe |=> STATUS_WRITE_OK) else $error("Protect under quad");
  a_quad_no_pause: assert property (
    qe |=> !PAUSED) else $error("Pause under quad");
  a_pause_low_clk: assert property (
    $rose(PAUSED) |-> $past(!s.ck2)) else $error("Pause on high clock");
  a_shared_reset: assert property (
    (rst_fn && !s.io2[3]) |=> DIE_RESET && !PAUSED)
    else $error("Shared reset missed");
  // Region lock, quiet pause, pause held on a high clock, pin reset
  a_array_lock: assert property (
    (hw_lock && REGION_PROTECTED) |=> !ARRAY_WRITE_OK)
    else $error("Array write open");
  a_pause_quiet: assert property (
    PAUSED |=> IO_OE == 4'h0) else $error("Driving while paused");
  a_pause_hold: assert property (
    (s.pstate == LINK_PAUSE && pause_fn && sel && s.ck2 && s.rp2)
    |=> PAUSED) else $error("Pause left on high clock");
  a_pin_reset: assert property (
    !s.rp2 |=> DIE_RESET && !ARMED) else $error("Pin reset missed");

endmodule
`default_nettype wire

//--- serial_flash_pin_interface_tb.sv
/*
  Self-checking bench for the flash pin interface.
  Assumes the host model drives the pins; lines 2 and 3 pull up.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_flash_pin_interface_tb;
  import flash_pin_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        rst_pin_n = 1'b1;
  status_cfg_t cfg = '0;
  lane_mode_t  lane = LANE_ONE;
  logic        tx_phase = 1'b0;
  logic [7:0]  tx_data = 8'h00;
  logic        tx_valid = 1'b0;
  logic        rx_ready = 1'b0;
  logic        op_busy = 1'b0;
  logic        region = 1'b0;
  logic [24:0] addr = 25'h000_0000;
  logic        cs_n;
  logic        sclk;
  logic [3:0]  h_drv;
  logic [3:0]  h_en;
  logic [3:0]  pin;
  logic [3:0]  last = 4'h0;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic [7:0]  rx;
  logic [7:0]  rx_data;
  logic        rx_valid;
  addr_map_t   addr_map;
  logic        power_active, standby, die_reset, paused, armed;
  logic        status_write_ok, array_write_ok, rx_overrun;
  int          bad_count = 0;
  int          checks = 0;
  logic [24:0] addr_list [6] = '{25'h000_0000, 25'h000_7fff,
    25'h000_8000, 25'h1fe_ffff, 25'h1ff_f000, 25'h1ff_ffff};
  // Expected fields per address: sector, half, block, big, last
  addr_map_t   addr_exp [6] = '{
    '{13'h0000, 10'h000, 9'h000, 6'h00, 1'b0},
    '{13'h0007, 10'h000, 9'h000, 6'h00, 1'b0},
    '{13'h0008, 10'h001, 9'h000, 6'h00, 1'b0},
    '{13'h1fef, 10'h3fd, 9'h1fe, 6'h3f, 1'b0},
    '{13'h1fff, 10'h3ff, 9'h1ff, 6'h3f, 1'b1},
    '{13'h1fff, 10'h3ff, 9'h1ff, 6'h3f, 1'b1}};
  logic        tx_take;
  int          takes = 0;

  // ==========================================================
  // Clock, parts and the wire level of the data lines
  always #50 mclk = ~mclk;

  // Released lines 0 and 1 drift so a stale value never passes
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (io_oe[k]) pin[k] = io_out[k];
      else if (h_en[k]) pin[k] = h_drv[k];
      else pin[k] = (k > 1) ? 1'b1 : ~last[k];
    end
  end
  always @(posedge mclk) last <= pin;

  // Count byte loads seen on the one-cycle take strobe
  always @(posedge mclk) if (tx_take === 1'b1) takes++;

  host_model u_host_model (.mclk(mclk), .cs_n(cs_n), .sclk(sclk),
    .drv(h_drv), .en(h_en), .pin(pin));

  serial_flash_pin_interface u_serial_flash_pin_interface (
    .MCLK(mclk), .RESET(reset), .CS_N(cs_n), .SCLK(sclk),
    .IO_IN(pin), .IO_OUT(io_out), .IO_OE(io_oe),
    .RESET_PIN_N(rst_pin_n), .STATUS_CFG(cfg), .LANE_MODE(lane),
    .TX_PHASE(tx_phase), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_TAKE(tx_take), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_OVERRUN(rx_overrun), .OP_BUSY(op_busy),
    .REGION_PROTECTED(region), .ADDR(addr), .ADDR_MAP(addr_map),
    .POWER_ACTIVE(power_active), .STANDBY(standby),
    .DIE_RESET(die_reset), .PAUSED(paused), .ARMED(armed),
    .STATUS_WRITE_OK(status_write_ok),
    .ARRAY_WRITE_OK(array_write_ok));

  // ==========================================================
  // Shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input logic [38:0] got, input logic [38:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded wait for the buffer head, then pop it
  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    if (n == 40) begin
      bad_count++;
      finish_test();
    end
    check(rx_data, exp);
    rx_ready = 1'b1;
    step(1);
    rx_ready = 1'b0;
    step(1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    step(3);
    reset = 1'b0;
    step(2);
    check(standby, 1'b1);
    check(armed, 1'b0);
    // Stalled consumer: two bytes kept, the third is lost
    u_host_model.sel(1'b1);
    check(power_active, 1'b1);
    check(armed, 1'b1);
    u_host_model.xfer(8'ha5, 1, 1'b0, rx);
    u_host_model.xfer(8'h3c, 1, 1'b0, rx);
    u_host_model.xfer(8'h96, 1, 1'b0, rx);
    step(6);
    check(rx_overrun, 1'b1);
    pop(8'ha5);
    pop(8'h3c);
    check(rx_valid, 1'b0);
    lane = LANE_TWO;
    u_host_model.xfer(8'h4b, 2, 1'b0, rx);
    pop(8'h4b);
    cfg = status_cfg_t'(4'h2);
    lane = LANE_FOUR;
    u_host_model.xfer(8'hd2, 4, 1'b0, rx);
    pop(8'hd2);
    // Read-out on line 1, one bit per falling edge
    cfg = '0;
    lane = LANE_ONE;
    tx_phase = 1'b1;
    tx_data = 8'h3c;
    tx_valid = 1'b1;
    u_host_model.xfer(8'h00, 1, 1'b1, rx);
    check(rx, 8'h3c);
    check(io_oe, 4'h2);
    // Dual read-out: the next byte leaves in pairs on lines 1 and 0
    lane = LANE_TWO;
    tx_data = 8'h96;
    u_host_model.xfer(8'h00, 2, 1'b1, rx);
    check(rx, 8'h96);
    check(io_oe, 4'h3);
    check(takes, 2);
    lane = LANE_ONE;
    tx_valid = 1'b0;
    tx_phase = 1'b0;
    // Deselected: lines released, clocking ignored, standby
    u_host_model.sel(1'b0);
    check(io_oe, 4'h0);
    u_host_model.xfer(8'h11, 1, 1'b0, rx);
    step(6);
    check(rx_valid, 1'b0);
    op_busy = 1'b1;
    step(3);
    check(power_active, 1'b1);
    op_busy = 1'b0;
    step(3);
    check(standby, 1'b1);
    // Hardware protection through line 2
    cfg = status_cfg_t'(4'h4);
    u_host_model.pins(1'b1, 4'h4, 4'h0);
    step(6);
    check(status_write_ok, 1'b0);
    region = 1'b1;
    step(2);
    check(array_write_ok, 1'b0);
    cfg = status_cfg_t'(4'h6);
    step(2);
    check(status_write_ok, 1'b1);
    region = 1'b0;
    cfg = '0;
    // Pause waits for a low clock on entry and on exit
    u_host_model.sel(1'b1);
    u_host_model.pins(1'b1, 4'h8, 4'h0);
    step(6);
    check(paused, 1'b0);
    u_host_model.pins(1'b0, 4'h8, 4'h0);
    step(6);
    check(paused, 1'b1);
    u_host_model.pins(1'b1, 4'h0, 4'h0);
    step(6);
    check(paused, 1'b1);
    u_host_model.pins(1'b0, 4'h0, 4'h0);
    step(6);
    check(paused, 1'b0);
    // Quad on: line 3 low neither pauses nor resets
    cfg = status_cfg_t'(4'h2);
    u_host_model.pins(1'b0, 4'h8, 4'h0);
    step(6);
    check(paused, 1'b0);
    check(die_reset, 1'b0);
    cfg = status_cfg_t'(4'h1);
    step(6);
    check(die_reset, 1'b1);
    u_host_model.pins(1'b0, 4'h0, 4'h0);
    step(6);
    check(armed, 1'b0);
    u_host_model.xfer(8'h5a, 1, 1'b0, rx);
    step(6);
    check(rx_valid, 1'b0);
    rst_pin_n = 1'b0;
    step(6);
    check(die_reset, 1'b1);
    rst_pin_n = 1'b1;
    step(6);
    check(die_reset, 1'b0);
    u_host_model.sel(1'b0);
    // Address map across boundaries
    foreach (addr_list[i]) begin
      addr = addr_list[i];
      step(2);
      check(addr_map, addr_exp[i]);
    end
    check(addr_map.sector, 13'h1fff);
    finish_test();
  end
endmodule
`default_nettype wire
